// ---- include/fpmc_pkg.sv ----
// Shared constants and carriers for the panel memory console
// Behaviour
// - Offset and data byte come from switches 0 to 7, bit 0 lowest.
// - Block number comes from switches 8 to 13, upper six address bits.
// - Load-address key copies all 14 switch bits into the address buffer.
// - A loaded address is shown on the indicators at once.
// - Store-byte key writes switches 0 to 7 to the buffered address.
// - After a store the written byte shows on indicators 0 to 7.
// - Read-byte key reads the addressed location and shows its contents.
// - Run-from-address key starts execution at the switch register address.
// - One-step mode holds ready low, so the processor waits.
// - Each step key press lets exactly one machine cycle run.
// - After each stepped cycle the accessed address is shown.
// - Raising the halt switch alone stops the processor.
// - Load, read and store are accepted only while halted.
// - Holding show-location while halted after a read shows the read address on 0 to 13.
// - Successive stores advance the address buffer by one.
// - Successive reads advance the address buffer by one.
// - A step releases the processor into TS3; it then waits again.
package fpmc_pkg;
    localparam int ADDR_W       = 14;
    localparam int DATA_W       = 8;
    localparam int OFS_LSB      = 0;
    localparam int OFS_MSB      = 7;
    localparam int BLK_LSB      = 8;
    localparam int BLK_MSB      = 13;
    localparam int NUM_KEYS     = 6;
    localparam int KEY_LOAD     = 0;
    localparam int KEY_STORE    = 1;
    localparam int KEY_READ     = 2;
    localparam int KEY_RUN      = 3;
    localparam int KEY_STEP     = 4;
    localparam int KEY_SHOWB    = 5;
    localparam int CLK_MHZ      = 100;
    localparam int DEBOUNCE_US  = 5;
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
    localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    // Memory request toward the processor module
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fpmc_mem_req_t;

    // Sequencer states, Gray coded in declaration order
    typedef enum logic [2:0] {
        FPMC_IDLE  = 3'b000,
        FPMC_WRITE = 3'b001,
        FPMC_READ  = 3'b011,
        FPMC_RDWT  = 3'b010,
        FPMC_STEP  = 3'b110
    } fpmc_state_t;

    // Indicator source selection
    typedef enum logic [1:0] {
        FPMC_SHOW_ADDR = 2'b00,
        FPMC_SHOW_DATA = 2'b01,
        FPMC_SHOW_BUS  = 2'b11
    } fpmc_show_t;
endpackage : fpmc_pkg

// ---- logic/fpmc_console.sv ----
// Front panel memory console: keys, address buffer, stepping and display
module fpmc_console #(
    parameter int DEBOUNCE = fpmc_pkg::DEBOUNCE_CYC
) (
    input  wire logic                          mclk_i,
    input  wire logic                          reset_i,
    input  wire logic [fpmc_pkg::ADDR_W-1:0]   switch_reg_i,
    input  wire logic [fpmc_pkg::NUM_KEYS-1:0] keys_i,
    input  wire logic                          show_location_key_i,
    input  wire logic                          halt_switch_i,
    input  wire logic                          one_step_select_i,
    input  wire logic [fpmc_pkg::ADDR_W-1:0]   cpu_addr_i,
    input  wire logic                          cpu_cycle_end_i,
    input  wire logic                          cpu_halted_i,
    input  wire logic                          mem_ack_i,
    input  wire logic [fpmc_pkg::DATA_W-1:0]   mem_rdata_i,
    output fpmc_pkg::fpmc_mem_req_t            mem_req_o,
    output logic                               cpu_ready_o,
    output logic                               cpu_halt_o,
    output logic                               cpu_start_o,
    output logic [fpmc_pkg::ADDR_W-1:0]        cpu_start_addr_o,
    output logic [fpmc_pkg::ADDR_W-1:0]        indicators_o,
    output logic                               wait_lamp_o
);
    import fpmc_pkg::*;

    localparam int DB_W = $clog2(DEBOUNCE + 1);
    // Reset view of the switches is the halt position, so the processor is not let go while the sync fills
    localparam logic [NUM_KEYS+2:0] SYNC_RST = (NUM_KEYS+3)'(1) << (NUM_KEYS + 1);

    // Pin synchronisers; first stage read only by the second
    logic [NUM_KEYS+2:0] sync1_q;
    logic [NUM_KEYS+2:0] sync2_q;
    logic [ADDR_W-1:0]   sw1_q;
    logic [ADDR_W-1:0]   sw2_q;
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
            sw1_q   <= ADDR_RST;
            sw2_q   <= ADDR_RST;
        end else begin
            sync1_q <= {one_step_select_i, halt_switch_i, show_location_key_i, keys_i};
            sync2_q <= sync1_q;
            sw1_q   <= switch_reg_i;
            sw2_q   <= sw1_q;
        end
    end

    wire logic halted    = sync2_q[NUM_KEYS+1];
    wire logic one_step  = sync2_q[NUM_KEYS+2];
    wire logic show_loc  = sync2_q[NUM_KEYS];

    // Per-key debounce: a level must hold DEBOUNCE cycles before it counts
    logic [NUM_KEYS-1:0] stable_q;
    logic [NUM_KEYS-1:0] press_q;
    genvar k;
    generate
        for (k = 0; k < NUM_KEYS; k++) begin : g_key
            logic [DB_W-1:0] cnt_q;
            always_ff @(posedge mclk_i) begin
                if (reset_i) begin
                    cnt_q       <= '0;
                    stable_q[k] <= 1'b0;
                    press_q[k]  <= 1'b0;
                end else begin
                    press_q[k] <= 1'b0;
                    if (sync2_q[k] == stable_q[k]) begin
                        cnt_q <= '0;
                    end else if (cnt_q == DB_W'(DEBOUNCE - 1)) begin
                        cnt_q       <= '0;
                        stable_q[k] <= sync2_q[k];
                        press_q[k]  <= sync2_q[k];
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
            end
        end
    endgenerate

    fpmc_state_t       state_q;
    logic [ADDR_W-1:0] abuf_q;
    logic [DATA_W-1:0] data_q;
    logic [ADDR_W-1:0] read_addr_q;
    logic [ADDR_W-1:0] bus_addr_q;
    fpmc_show_t        show_q;

    wire logic panel_ok = halted && (state_q == FPMC_IDLE);

    // Memory access sequencer; a busy panel ignores further keys
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q   <= FPMC_IDLE;
            mem_req_o <= '0;
        end else begin
            unique case (state_q)
                FPMC_IDLE: begin
                    if (panel_ok && press_q[KEY_STORE]) begin
                        mem_req_o.wr    <= 1'b1;
                        mem_req_o.addr  <= abuf_q;
                        mem_req_o.wdata <= sw2_q[OFS_MSB:OFS_LSB];
                        state_q         <= FPMC_WRITE;
                    end else if (panel_ok && press_q[KEY_READ]) begin
                        mem_req_o.rd   <= 1'b1;
                        mem_req_o.addr <= abuf_q;
                        state_q        <= FPMC_READ;
                    end else if (!halted && one_step && press_q[KEY_STEP]) begin
                        state_q <= FPMC_STEP;
                    end
                end
                FPMC_WRITE, FPMC_READ: begin
                    if (mem_ack_i) begin
                        mem_req_o.wr <= 1'b0;
                        mem_req_o.rd <= 1'b0;
                        state_q      <= (state_q == FPMC_READ) ? FPMC_RDWT : FPMC_IDLE;
                    end
                end
                FPMC_RDWT: state_q <= FPMC_IDLE;
                FPMC_STEP: begin
                    // Ready is released until the processor reports one finished cycle
                    if (cpu_cycle_end_i || halted || !one_step) begin
                        state_q <= FPMC_IDLE;
                    end
                end
                default: state_q <= FPMC_IDLE;
            endcase
        end
    end

    // Address buffer: load from switches, advance after each store or read
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            abuf_q      <= ADDR_RST;
            read_addr_q <= ADDR_RST;
        end else begin
            if (panel_ok && press_q[KEY_LOAD]) begin
                abuf_q <= {sw2_q[BLK_MSB:BLK_LSB], sw2_q[OFS_MSB:OFS_LSB]};
            end else if (state_q == FPMC_IDLE && !halted && press_q[KEY_RUN]) begin
                abuf_q <= sw2_q;
            end else if ((state_q == FPMC_WRITE || state_q == FPMC_READ) && mem_ack_i) begin
                if (state_q == FPMC_READ) begin
                    read_addr_q <= abuf_q;
                end
                abuf_q <= abuf_q + 1'b1;
            end
        end
    end

    // Data latch and display selection
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            data_q     <= DATA_RST;
            show_q     <= FPMC_SHOW_ADDR;
            bus_addr_q <= ADDR_RST;
        end else begin
            if (panel_ok && press_q[KEY_LOAD]) begin
                show_q <= FPMC_SHOW_ADDR;
            end else if (state_q == FPMC_WRITE && mem_ack_i) begin
                data_q <= mem_req_o.wdata;
                show_q <= FPMC_SHOW_DATA;
            end else if (state_q == FPMC_READ && mem_ack_i) begin
                data_q <= mem_rdata_i;
                show_q <= FPMC_SHOW_DATA;
            end else if (state_q == FPMC_STEP && cpu_cycle_end_i) begin
                bus_addr_q <= cpu_addr_i;
                show_q     <= FPMC_SHOW_BUS;
            end else if (!halted && !one_step) begin
                show_q <= FPMC_SHOW_BUS;
            end
            if (!halted && !one_step) begin
                bus_addr_q <= cpu_addr_i;
            end
        end
    end

    // Processor control: halt, start pulse, ready gating
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cpu_halt_o       <= 1'b1;
            cpu_start_o      <= 1'b0;
            cpu_start_addr_o <= ADDR_RST;
            cpu_ready_o      <= 1'b0;
            wait_lamp_o      <= 1'b0;
        end else begin
            cpu_halt_o  <= halted;
            cpu_start_o <= 1'b0;
            if (state_q == FPMC_IDLE && !halted && press_q[KEY_RUN]) begin
                cpu_start_o      <= 1'b1;
                cpu_start_addr_o <= sw2_q;
            end
            // Ready low parks the processor between TS2 and TS3
            cpu_ready_o <= !one_step || (state_q == FPMC_STEP && !cpu_cycle_end_i);
            wait_lamp_o <= one_step && !halted && !cpu_halted_i
                           && !(state_q == FPMC_STEP && !cpu_cycle_end_i);
        end
    end

    // Indicators; show-location overrides while held and halted after a read
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            indicators_o <= ADDR_RST;
        end else if (show_loc && halted) begin
            indicators_o <= read_addr_q;
        end else begin
            unique case (show_q)
                FPMC_SHOW_ADDR: indicators_o <= abuf_q;
                FPMC_SHOW_DATA: indicators_o <= {{(ADDR_W-DATA_W){1'b0}}, data_q};
                FPMC_SHOW_BUS:  indicators_o <= bus_addr_q;
                default:        indicators_o <= abuf_q;
            endcase
        end
    end
endmodule : fpmc_console

// ---- bench/fpmc_console_properties.sv ----
// Port checker for the panel memory console
module fpmc_console_properties #(
    parameter int DEBOUNCE = fpmc_pkg::DEBOUNCE_CYC
) (
    input wire logic                            mclk_i,
    input wire logic                            reset_i,
    input wire logic [fpmc_pkg::ADDR_W-1:0]     switch_reg_i,
    input wire logic                            halt_switch_i,
    input wire logic                            one_step_select_i,
    input wire logic [fpmc_pkg::ADDR_W-1:0]     cpu_addr_i,
    input wire logic                            cpu_cycle_end_i,
    input wire logic                            mem_ack_i,
    input wire logic [fpmc_pkg::DATA_W-1:0]     mem_rdata_i,
    input wire fpmc_pkg::fpmc_mem_req_t         mem_req_o,
    input wire logic                            cpu_ready_o,
    input wire logic                            cpu_halt_o,
    input wire logic                            cpu_start_o,
    input wire logic [fpmc_pkg::ADDR_W-1:0]     cpu_start_addr_o,
    input wire logic [fpmc_pkg::ADDR_W-1:0]     indicators_o
);
    import fpmc_pkg::*;
    logic [DATA_W-1:0] byte_q;
    logic [ADDR_W-1:0] step_q;
    // Byte the lamps must show after a transfer, and address after a step
    always_ff @(posedge mclk_i) begin
        if (mem_ack_i) begin
            byte_q <= mem_req_o.wr ? mem_req_o.wdata : mem_rdata_i;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (cpu_cycle_end_i) begin
            step_q <= cpu_addr_i;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    a_store_show_byte: assert property (mem_req_o.wr && mem_ack_i |-> ##[1:3] indicators_o == {6'h00, byte_q})
        else $error("stored byte not shown");
    a_read_show_byte: assert property (mem_req_o.rd && mem_ack_i |-> ##[1:3] indicators_o == {6'h00, byte_q})
        else $error("read byte not shown");
    a_req_held: assert property ((mem_req_o.wr || mem_req_o.rd) && !mem_ack_i |=> $stable(mem_req_o))
        else $error("request changed before ack");
    a_req_release: assert property ((mem_req_o.wr || mem_req_o.rd) && mem_ack_i |=> !(mem_req_o.wr || mem_req_o.rd))
        else $error("request held after ack");
    a_only_halted: assert property ($rose(mem_req_o.wr || mem_req_o.rd) |-> halt_switch_i)
        else $error("memory access while running");
    a_start_once: assert property (cpu_start_o |=> !cpu_start_o)
        else $error("start pulse too long");
    a_start_addr: assert property (cpu_start_o |-> cpu_start_addr_o == switch_reg_i)
        else $error("start address differs from switches");
    a_step_one: assert property (one_step_select_i && $past(one_step_select_i, 4) && cpu_ready_o && cpu_cycle_end_i |=> !cpu_ready_o)
        else $error("ready kept after stepped cycle");
    a_step_show: assert property (one_step_select_i && $past(one_step_select_i, 4) && cpu_ready_o && cpu_cycle_end_i |-> ##[1:3] indicators_o == step_q)
        else $error("stepped address not shown");
    a_halt_follow: assert property (halt_switch_i [*4] |=> cpu_halt_o)
        else $error("halt switch ignored");
    c_store: cover property (mem_req_o.wr && mem_ack_i);
    c_read: cover property (mem_req_o.rd && mem_ack_i);
    c_step: cover property (one_step_select_i && cpu_ready_o && cpu_cycle_end_i);
endmodule : fpmc_console_properties

// ---- bench/fpmc_far_side.sv ----
// Far side model: byte memory and a processor that runs cycles while ready
module fpmc_far_side (
    input  wire logic                        mclk_i,
    input  wire logic                        reset_i,
    input  wire fpmc_pkg::fpmc_mem_req_t     mem_req_i,
    input  wire logic                        cpu_ready_i,
    input  wire logic                        cpu_start_i,
    input  wire logic [fpmc_pkg::ADDR_W-1:0] cpu_start_addr_i,
    output logic                             mem_ack_o,
    output logic [fpmc_pkg::DATA_W-1:0]      mem_rdata_o,
    output logic                             cpu_cycle_end_o,
    output logic [fpmc_pkg::ADDR_W-1:0]      cpu_addr_o
);
    import fpmc_pkg::*;
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [1:0]        wait_q;
    logic [1:0]        phase_q;
    // Answer after a wait; read data toggles outside ack so stale bytes never match
    always_ff @(posedge mclk_i) begin
        mem_ack_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        if (reset_i) begin
            wait_q <= 2'h0;
            mem_rdata_o <= 8'h5a;
        end else if ((mem_req_i.wr || mem_req_i.rd) && !mem_ack_o) begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == 2'h2) begin
                wait_q <= 2'h0;
                mem_ack_o <= 1'b1;
                mem_rdata_o <= mem[mem_req_i.addr];
                if (mem_req_i.wr) begin
                    mem[mem_req_i.addr] <= mem_req_i.wdata;
                end
            end
        end
    end
    // Every third ready clock ends a machine cycle and moves to the next byte
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            phase_q <= 2'h0;
            cpu_cycle_end_o <= 1'b0;
            cpu_addr_o <= 14'h0100;
        end else begin
            cpu_cycle_end_o <= cpu_ready_i && phase_q == 2'h2;
            phase_q <= (cpu_ready_i && phase_q != 2'h2) ? phase_q + 2'h1 : 2'h0;
            if (cpu_start_i) begin
                cpu_addr_o <= cpu_start_addr_i;
            end else if (cpu_cycle_end_o) begin
                cpu_addr_o <= cpu_addr_o + 14'h0001;
            end
        end
    end
endmodule : fpmc_far_side

// ---- bench/fpmc_console_test.sv ----
// Self-checking bench for the panel memory console
module fpmc_console_test;
    timeunit 1ns;
    timeprecision 1ps;
    import fpmc_pkg::*;
    logic                mclk_i = 1'b0;
    logic                reset_i = 1'b1;
    logic [ADDR_W-1:0]   switch_reg_i = 14'h0000;
    logic [NUM_KEYS-1:0] keys_i = 6'h00;
    logic                show_location_key_i = 1'b0;
    logic                halt_switch_i = 1'b1;
    logic                one_step_select_i = 1'b0;
    logic [ADDR_W-1:0]   cpu_addr_i, cpu_start_addr_o, indicators_o;
    logic [DATA_W-1:0]   mem_rdata_i;
    logic                cpu_cycle_end_i, mem_ack_i, cpu_ready_o, cpu_halt_o, cpu_start_o, wait_lamp_o;
    fpmc_mem_req_t       mem_req_o;
    int                  bad_count = 0;
    int                  samples_checked = 0;
    always #5 mclk_i = ~mclk_i;
    fpmc_console #(.DEBOUNCE(3)) DUT (.mclk_i, .reset_i, .switch_reg_i, .keys_i, .show_location_key_i,
        .halt_switch_i, .one_step_select_i, .cpu_addr_i, .cpu_cycle_end_i, .cpu_halted_i(1'b0), .mem_ack_i,
        .mem_rdata_i, .mem_req_o, .cpu_ready_o, .cpu_halt_o, .cpu_start_o, .cpu_start_addr_o, .indicators_o,
        .wait_lamp_o);
    fpmc_far_side far_side (.mclk_i, .reset_i, .mem_req_i(mem_req_o), .cpu_ready_i(cpu_ready_o),
        .cpu_start_i(cpu_start_o), .cpu_start_addr_i(cpu_start_addr_o), .mem_ack_o(mem_ack_i),
        .mem_rdata_o(mem_rdata_i), .cpu_cycle_end_o(cpu_cycle_end_i), .cpu_addr_o(cpu_addr_i));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic hold(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : hold
    // Keys are held well past debounce so exactly one press is seen
    task automatic press(input int k);
        keys_i[k] = 1'b1;
        hold(12);
        keys_i[k] = 1'b0;
        hold(12);
    endtask : press
    task automatic store_seq();
        logic [7:0] d [3] = '{8'ha5, 8'h3c, 8'h77};
        switch_reg_i = 14'h2a5c;
        press(KEY_LOAD);
        chk(indicators_o, 14'h2a5c);
        switch_reg_i = 14'h3ffe;
        press(KEY_LOAD);
        for (int i = 0; i < 3; i++) begin
            switch_reg_i = {6'h15, d[i]}; // Block bits must not leak into the byte
            press(KEY_STORE);
            chk(indicators_o, {6'h00, d[i]});
            chk(far_side.mem[14'(14'h3ffe + i)], d[i]);
        end
    endtask : store_seq
    task automatic read_seq();
        switch_reg_i = 14'h3ffe;
        press(KEY_LOAD);
        for (int i = 0; i < 2; i++) begin
            press(KEY_READ);
            chk(indicators_o, {6'h00, i ? 8'h3c : 8'ha5});
        end
        show_location_key_i = 1'b1;
        hold(8);
        chk(indicators_o, 14'h3fff);
        show_location_key_i = 1'b0;
        hold(4);
    endtask : read_seq
    task automatic step_seq();
        logic [13:0] at;
        int          ends;
        halt_switch_i = 1'b0;
        one_step_select_i = 1'b1;
        switch_reg_i = 14'h0011;
        hold(10);
        press(KEY_STORE);
        chk(far_side.mem[0], 8'h77);
        chk({cpu_ready_o, wait_lamp_o}, 2'b01);
        ends = 0;
        keys_i[KEY_STEP] = 1'b1;
        repeat (40) begin
            @(negedge mclk_i);
            if (cpu_cycle_end_i === 1'b1) begin
                ends++;
                at = cpu_addr_i;
            end
        end
        keys_i[KEY_STEP] = 1'b0;
        hold(12);
        chk(16'(ends), 16'h0001);
        chk(indicators_o, at);
        chk({cpu_ready_o, wait_lamp_o}, 2'b01);
    endtask : step_seq
    task automatic run_seq();
        int starts;
        one_step_select_i = 1'b0;
        switch_reg_i = 14'h1234;
        starts = 0;
        hold(6);
        keys_i[KEY_RUN] = 1'b1;
        repeat (20) begin
            @(negedge mclk_i);
            if (cpu_start_o === 1'b1) begin
                starts++;
                chk(cpu_start_addr_o, 14'h1234);
            end
        end
        keys_i[KEY_RUN] = 1'b0;
        hold(12);
        chk(16'(starts), 16'h0001);
        chk(cpu_halt_o, 1'b0);
        halt_switch_i = 1'b1;
        hold(6);
        chk(cpu_halt_o, 1'b1);
    endtask : run_seq
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    initial begin
        hold(20);
        reset_i = 1'b0;
        hold(4);
        chk({cpu_halt_o, cpu_start_o, indicators_o}, {2'b10, 14'h0000});
        store_seq();
        read_seq();
        step_seq();
        run_seq();
        results();
    end
    // Whole run needs well under 2000 clocks
    initial begin
        #50us;
        bad_count++;
        results();
    end
endmodule : fpmc_console_test
bind fpmc_console fpmc_console_properties #(.DEBOUNCE(DEBOUNCE)) u_props (.mclk_i, .reset_i, .switch_reg_i,
    .halt_switch_i, .one_step_select_i, .cpu_addr_i, .cpu_cycle_end_i, .mem_ack_i, .mem_rdata_i, .mem_req_o,
    .cpu_ready_o, .cpu_halt_o, .cpu_start_o, .cpu_start_addr_o, .indicators_o);
